//--- include/sps_pkg.sv
// Operation
// - Fast mode: one window over all channels
// - Fast mode: period is window then off
// - Fast mode: receiver off once search ends
// - Mixed: A constant timing, B fast timing
// - Mixed: A window per enabled A channel
// - Mixed: one B window over B channels
// - Mixed: period is A windows, B, off
// - Permanent search: fast behaviour, no sleep
// - Permanent search: restart at first channel
// - Active/idle skips whole periods in any mode
// - Control bit 3 enables permanent search in constant mode
// - Control bit 2 enables active/idle selection
// - Control bits 1:0 select polling mode
// - Prescaled tick every 64 clocks
// - Reference tick every 64 times setting
// - Reference tick clocks the interval timers
// - Fast mode uses only the A window
// - Off interval is setting times tick, 0=16384
// - Active count five bits, zero means 256
// - Idle count eight bits, zero means 256
package sps_pkg;

    localparam logic [7:0] ADDR_CTRL    = 8'h07;
    localparam logic [7:0] ADDR_REFDIV  = 8'h08;
    localparam logic [7:0] ADDR_OFF_LO  = 8'h09;
    localparam logic [7:0] ADDR_OFF_HI  = 8'h0a;
    localparam logic [7:0] ADDR_ACTIVE  = 8'h0b;
    localparam logic [7:0] ADDR_IDLE    = 8'h0c;
    localparam logic [7:0] ADDR_STATUS  = 8'h0d;
    localparam logic [7:0] ADDR_A_ON    = 8'h0e;
    localparam logic [7:0] ADDR_B_ON    = 8'h0f;
    localparam logic [7:0] ADDR_CHAN_EN = 8'h10;

    localparam int CTRL_PERM_BIT = 3;
    localparam int CTRL_AI_BIT   = 2;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CHAN_B_LSB    = 4;

    localparam logic [1:0] MODE_CONST = 2'h0;
    localparam logic [1:0] MODE_FAST  = 2'h1;
    localparam logic [1:0] MODE_MIXED = 2'h2;
    localparam logic [1:0] MODE_UNDEF = 2'h3;

    localparam logic [7:0] RST_CTRL    = 8'h00;
    localparam logic [7:0] RST_REFDIV  = 8'h01;
    localparam logic [7:0] RST_OFF_LO  = 8'h01;
    localparam logic [5:0] RST_OFF_HI  = 6'h00;
    localparam logic [4:0] RST_ACTIVE  = 5'h01;
    localparam logic [7:0] RST_IDLE    = 8'h01;
    localparam logic [7:0] RST_A_ON    = 8'h01;
    localparam logic [7:0] RST_B_ON    = 8'h01;
    localparam logic [3:0] RST_EN_A    = 4'h1;
    localparam logic [3:0] RST_EN_B    = 4'h0;

    localparam int PRESCALE   = 64;
    localparam int NUM_A      = 3;
    localparam int NUM_B      = 2;
    localparam int MAX_CH_CFG = 4;
    localparam int CH_W       = 3;

    typedef struct packed {
        logic [1:0]  mode;
        logic        perm;
        logic        ai;
        logic [7:0]  a_on;
        logic [7:0]  b_on;
        logic [13:0] off;
        logic [4:0]  act;
        logic [7:0]  idle;
        logic [3:0]  en_a;
        logic [3:0]  en_b;
    } sps_cfg_s;

    typedef enum logic [3:0] {
        ST_LOAD  = 4'h1,
        ST_START = 4'h2,
        ST_ON    = 4'h4,
        ST_OFF   = 4'h8
    } sps_state_e;

endpackage : sps_pkg

//--- src/sps_sequencer.sv
`timescale 1ns/1ps
module sps_sequencer #(
    parameter int NUM_A    = sps_pkg::NUM_A,
    parameter int NUM_B    = sps_pkg::NUM_B,
    parameter int PRESCALE = sps_pkg::PRESCALE
) (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        search_done,
    output logic             rx_on,
    output logic             search_cfg_b,
    output logic [2:0]       search_index,
    output logic             chan_start,
    output logic             period_start,
    output logic             idle_period
);
    localparam int NCH = NUM_A + NUM_B;

    initial begin
        if (NUM_A < 1 || NUM_A > sps_pkg::MAX_CH_CFG || NUM_B < 1 ||
            NUM_B > sps_pkg::MAX_CH_CFG) begin
            $error("channel counts out of range");
        end
    end

    sps_pkg::sps_cfg_s   cfg;
    sps_pkg::sps_cfg_s   sh;
    sps_pkg::sps_state_e state;
    sps_pkg::sps_state_e next_state;
    logic [7:0]          ref_div;
    logic                pre_tick;
    logic                ref_tick;
    logic [2:0]          cur;
    logic [2:0]          next_cur;
    logic [8:0]          win_cnt;
    logic [8:0]          next_win;
    logic [14:0]         off_cnt;
    logic [14:0]         next_off;
    logic                searching;
    logic                next_search;
    logic                next_chan_start;
    logic                idle_ph;
    logic [8:0]          per_cnt;

    sps_tick_gen #(
        .PRESCALE (PRESCALE)
    ) u_tick (
        .sys_clk  (sys_clk),
        .resetn   (resetn),
        .ref_div  (ref_div),
        .pre_tick (pre_tick),
        .ref_tick (ref_tick)
    );

    // Register decode
    wire wr_ctrl   = reg_wr && (reg_addr == sps_pkg::ADDR_CTRL);
    wire wr_refdiv = reg_wr && (reg_addr == sps_pkg::ADDR_REFDIV);
    wire wr_off_lo = reg_wr && (reg_addr == sps_pkg::ADDR_OFF_LO);
    wire wr_off_hi = reg_wr && (reg_addr == sps_pkg::ADDR_OFF_HI);
    wire wr_active = reg_wr && (reg_addr == sps_pkg::ADDR_ACTIVE);
    wire wr_idle   = reg_wr && (reg_addr == sps_pkg::ADDR_IDLE);
    wire wr_a_on   = reg_wr && (reg_addr == sps_pkg::ADDR_A_ON);
    wire wr_b_on   = reg_wr && (reg_addr == sps_pkg::ADDR_B_ON);
    wire wr_en     = reg_wr && (reg_addr == sps_pkg::ADDR_CHAN_EN);
    wire rd_status = reg_rd && (reg_addr == sps_pkg::ADDR_STATUS);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cfg.mode <= sps_pkg::RST_CTRL[1:0];
            cfg.perm <= sps_pkg::RST_CTRL[sps_pkg::CTRL_PERM_BIT];
            cfg.ai   <= sps_pkg::RST_CTRL[sps_pkg::CTRL_AI_BIT];
            cfg.a_on <= sps_pkg::RST_A_ON;
            cfg.b_on <= sps_pkg::RST_B_ON;
            cfg.off  <= {sps_pkg::RST_OFF_HI, sps_pkg::RST_OFF_LO};
            cfg.act  <= sps_pkg::RST_ACTIVE;
            cfg.idle <= sps_pkg::RST_IDLE;
            cfg.en_a <= sps_pkg::RST_EN_A;
            cfg.en_b <= sps_pkg::RST_EN_B;
            ref_div  <= sps_pkg::RST_REFDIV;
        end else begin
            if (wr_ctrl) begin
                cfg.mode <= reg_wdata[sps_pkg::CTRL_MODE_LSB +: 2];
                cfg.perm <= reg_wdata[sps_pkg::CTRL_PERM_BIT];
                cfg.ai   <= reg_wdata[sps_pkg::CTRL_AI_BIT];
            end
            if (wr_refdiv) begin
                ref_div <= reg_wdata;
            end
            if (wr_off_lo) begin
                cfg.off[7:0] <= reg_wdata;
            end
            if (wr_off_hi) begin
                cfg.off[13:8] <= reg_wdata[5:0];
            end
            if (wr_active) begin
                cfg.act <= reg_wdata[4:0];
            end
            if (wr_idle) begin
                cfg.idle <= reg_wdata;
            end
            if (wr_a_on) begin
                cfg.a_on <= reg_wdata;
            end
            if (wr_b_on) begin
                cfg.b_on <= reg_wdata;
            end
            if (wr_en) begin
                cfg.en_a <= reg_wdata[3:0];
                cfg.en_b <= reg_wdata[sps_pkg::CHAN_B_LSB +: 4];
            end
        end
    end

    // Status and read data
    wire [7:0] status_byte = {idle_ph, searching, state == sps_pkg::ST_ON,
                              state == sps_pkg::ST_OFF, search_cfg_b, cur};
    wire [7:0] next_rdata  = rd_status ? status_byte : 8'h00;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // Mode decode from the period shadow
    wire is_mixed  = (sh.mode == sps_pkg::MODE_MIXED);
    wire is_fast   = (sh.mode == sps_pkg::MODE_FAST);
    wire is_const  = !is_mixed && !is_fast;
    wire perm_act  = is_const && sh.perm;
    wire fast_like = is_fast || perm_act;
    wire cur_b     = (cur >= 3'(NUM_A));
    wire per_chan  = (is_const && !sh.perm) || (is_mixed && !cur_b);

    wire [NCH-1:0] en_all = {sh.en_b[NUM_B-1:0], sh.en_a[NUM_A-1:0]};

    function automatic logic [3:0] find_from(input logic [NCH-1:0] en,
                                             input logic [3:0]     start);
        logic [3:0] res;
        res = 4'h0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (en[i] && (4'(i) >= start)) begin
                res = {1'b1, 3'(i)};
            end
        end
        return res;
    endfunction : find_from

    wire [3:0] first_res = find_from(en_all, 4'h0);
    wire [3:0] nxt_res   = find_from(en_all, {1'b0, cur} + 4'h1);
    wire       first_ok  = first_res[3];
    wire       nxt_ok    = nxt_res[3];
    wire [2:0] first_idx = first_res[2:0];
    wire [2:0] nxt_idx   = nxt_res[2:0];

    wire [8:0]  a_ext   = {sh.a_on == 8'h00, sh.a_on};
    wire [8:0]  b_ext   = {sh.b_on == 8'h00, sh.b_on};
    wire [14:0] off_ext = {sh.off == 14'h0000, sh.off};
    wire [8:0]  win_nxt   = (nxt_idx >= 3'(NUM_A)) ? b_ext : a_ext;
    wire [8:0]  win_first = fast_like ? a_ext :
                            ((first_idx >= 3'(NUM_A)) ? b_ext : a_ext);

    wire win_exp  = ref_tick && (win_cnt == 9'h001);
    wire off_exp  = ref_tick && (off_cnt == 15'h0001);
    wire adv_chan = per_chan ? win_exp : (search_done && searching && !win_exp);

    always_comb begin
        next_state      = state;
        next_cur        = cur;
        next_win        = win_cnt;
        next_off        = off_cnt;
        next_search     = searching;
        next_chan_start = 1'b0;
        case (state)
            sps_pkg::ST_LOAD: begin
                next_state = sps_pkg::ST_START;
            end
            sps_pkg::ST_START: begin
                if (first_ok) begin
                    next_state      = sps_pkg::ST_ON;
                    next_cur        = first_idx;
                    next_win        = win_first;
                    next_search     = 1'b1;
                    next_chan_start = 1'b1;
                end else begin
                    next_state = sps_pkg::ST_OFF;
                    next_off   = off_ext;
                end
            end
            sps_pkg::ST_ON: begin
                if (ref_tick) begin
                    next_win = win_cnt - 9'h001;
                end
                if (win_exp && !per_chan) begin
                    next_state  = sps_pkg::ST_OFF;
                    next_off    = off_ext;
                    next_search = 1'b0;
                end else if (adv_chan) begin
                    if (nxt_ok) begin
                        next_cur        = nxt_idx;
                        next_search     = 1'b1;
                        next_chan_start = 1'b1;
                        if (per_chan) begin
                            next_win = win_nxt;
                        end
                    end else if (per_chan) begin
                        next_state  = sps_pkg::ST_OFF;
                        next_off    = off_ext;
                        next_search = 1'b0;
                    end else if (perm_act) begin
                        next_cur        = first_idx;
                        next_chan_start = 1'b1;
                    end else begin
                        next_search = 1'b0;
                    end
                end
            end
            sps_pkg::ST_OFF: begin
                if (off_exp) begin
                    next_state = sps_pkg::ST_LOAD;
                end else if (ref_tick) begin
                    next_off = off_cnt - 15'h0001;
                end
            end
            default: begin
                next_state  = sps_pkg::ST_LOAD;
                next_search = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state        <= sps_pkg::ST_LOAD;
            cur          <= 3'h0;
            win_cnt      <= 9'h001;
            off_cnt      <= 15'h0001;
            searching    <= 1'b0;
            rx_on        <= 1'b0;
            chan_start   <= 1'b0;
            search_cfg_b <= 1'b0;
            period_start <= 1'b0;
        end else begin
            state        <= next_state;
            cur          <= next_cur;
            win_cnt      <= next_win;
            off_cnt      <= next_off;
            searching    <= next_search;
            rx_on        <= next_search && !idle_ph;
            chan_start   <= next_chan_start && !idle_ph;
            search_cfg_b <= (next_cur >= 3'(NUM_A));
            period_start <= (state == sps_pkg::ST_LOAD);
        end
    end

    assign search_index = cur;
    assign idle_period  = idle_ph;

    // Shadow settings and active/idle period counting
    wire [8:0] act_ext  = {cfg.act == 5'h00, 3'h0, cfg.act};
    wire [8:0] idle_ext = {cfg.idle == 8'h00, cfg.idle};
    wire       per_end  = (state == sps_pkg::ST_OFF) && off_exp;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sh.mode <= sps_pkg::RST_CTRL[1:0];
            sh.perm <= 1'b0;
            sh.ai   <= 1'b0;
            sh.a_on <= sps_pkg::RST_A_ON;
            sh.b_on <= sps_pkg::RST_B_ON;
            sh.off  <= {sps_pkg::RST_OFF_HI, sps_pkg::RST_OFF_LO};
            sh.act  <= sps_pkg::RST_ACTIVE;
            sh.idle <= sps_pkg::RST_IDLE;
            sh.en_a <= sps_pkg::RST_EN_A;
            sh.en_b <= sps_pkg::RST_EN_B;
            idle_ph <= 1'b0;
            per_cnt <= 9'h001;
        end else begin
            if (state == sps_pkg::ST_LOAD) begin
                sh <= cfg;
            end
            if (per_end) begin
                if (!sh.ai) begin
                    idle_ph <= 1'b0;
                    per_cnt <= act_ext;
                end else if (per_cnt == 9'h001) begin
                    idle_ph <= !idle_ph;
                    per_cnt <= idle_ph ? act_ext : idle_ext;
                end else begin
                    per_cnt <= per_cnt - 9'h001;
                end
            end
        end
    end

    shadow_stable_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state != sps_pkg::ST_LOAD) |=> $stable(sh))
        else $error("settings changed inside a period");

    fast_one_window_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state == sps_pkg::ST_ON && fast_like && !ref_tick) |=> $stable(win_cnt))
        else $error("fast window reloaded per channel");

    fast_start_a_window_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state == sps_pkg::ST_START && is_fast && first_ok) |=> win_cnt == $past(a_ext))
        else $error("fast window not taken from A setting");

    fast_fallback_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state == sps_pkg::ST_ON && is_fast && searching && search_done && !nxt_ok
         && !win_exp) |=> !searching ##0 !rx_on [*1] ##1 !rx_on)
        else $error("receiver kept on after search ended");

    perm_restart_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state == sps_pkg::ST_ON && perm_act && searching && search_done && !nxt_ok
         && !win_exp) |=> searching && cur == $past(first_idx) && state == sps_pkg::ST_ON)
        else $error("permanent search did not restart");

    mixed_a_reload_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state == sps_pkg::ST_ON && is_mixed && !cur_b && win_exp && nxt_ok)
        |=> win_cnt == $past(win_nxt) && chan_start == !idle_ph)
        else $error("mixed channel window not reloaded");

    group_end_off_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state == sps_pkg::ST_ON && !per_chan && win_exp)
        |=> state == sps_pkg::ST_OFF && off_cnt == $past(off_ext) && !searching)
        else $error("window end did not start off interval");

    off_counts_ticks_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state == sps_pkg::ST_OFF && !ref_tick) |=> $stable(off_cnt))
        else $error("off timer moved without reference tick");

    off_end_load_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        per_end |=> state == sps_pkg::ST_LOAD ##1 state == sps_pkg::ST_START)
        else $error("period did not restart after off interval");

    undef_as_const_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (state == sps_pkg::ST_START && sh.mode == sps_pkg::MODE_UNDEF && !sh.perm
         && first_ok) |=> win_cnt == $past(win_first) && !is_fast && per_chan)
        else $error("mode 11b not treated as constant");

    idle_gates_rx_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (idle_ph && $past(idle_ph)) |-> !rx_on && !chan_start)
        else $error("receiver active in idle period");

endmodule : sps_sequencer

//--- src/sps_tick_gen.sv
`timescale 1ns/1ps
module sps_tick_gen #(
    parameter int PRESCALE = sps_pkg::PRESCALE
) (
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic [7:0] ref_div,
    output logic            pre_tick,
    output logic            ref_tick
);
    localparam int PW = $clog2(PRESCALE);
    localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE - 1);

    initial begin
        if (PRESCALE < 2 || PRESCALE > 64) begin
            $error("PRESCALE out of range");
        end
    end

    logic [PW-1:0] pre_cnt;
    logic [7:0]    div_cnt;
    wire           div_last = (div_cnt == 8'(ref_div - 8'h01));

    assign pre_tick = (pre_cnt == PRE_LAST);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pre_cnt  <= '0;
            div_cnt  <= 8'h00;
            ref_tick <= 1'b0;
        end else begin
            pre_cnt  <= pre_tick ? '0 : pre_cnt + 1'b1;
            ref_tick <= pre_tick && div_last;
            if (pre_tick) begin
                div_cnt <= div_last ? 8'h00 : div_cnt + 8'h01;
            end
        end
    end

    logic [15:0] gap;
    logic        seen;
    logic        div_moved;
    logic [7:0]  pre_gap;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            gap       <= 16'h0000;
            seen      <= 1'b0;
            div_moved <= 1'b0;
            pre_gap   <= 8'h01;
        end else begin
            gap       <= ref_tick ? 16'h0001 : gap + 16'h0001;
            pre_gap   <= pre_tick ? 8'h01 : pre_gap + 8'h01;
            seen      <= seen | ref_tick;
            div_moved <= ref_tick ? 1'b0 : (div_moved | (ref_div != $past(ref_div)));
        end
    end

    prescale_period_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        pre_tick |-> pre_gap == 8'(PRESCALE))
        else $error("prescaled tick not every 64 clocks");

    ref_period_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (ref_tick && seen && !div_moved && ref_div == $past(ref_div))
        |-> gap == 16'(PRESCALE * ((ref_div == 8'h00) ? 256 : int'(ref_div))))
        else $error("reference tick period wrong");

endmodule : sps_tick_gen

//--- verification/sps_sequencer_tb_top.sv
`timescale 1ns/1ps
module sps_sequencer_tb_top;
    localparam int PS = 4;
    logic       sys_clk;
    logic       resetn;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       search_done;
    logic       rx_on;
    logic       search_cfg_b;
    logic [2:0] search_index;
    logic       chan_start;
    logic       period_start;
    logic       idle_period;
    int         bad_count;
    int         samples_checked;
    int         cyc;
    int         st;
    int         idl;
    int         onc;
    logic [2:0] idx_q[$];
    logic       b_q[$];
    int         cy_q[$];

    sps_sequencer #(.PRESCALE(PS)) sps_sequencer_i (
        .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .search_done(search_done),
        .rx_on(rx_on), .search_cfg_b(search_cfg_b), .search_index(search_index),
        .chan_start(chan_start), .period_start(period_start), .idle_period(idle_period));

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
    endtask : wr

    task automatic cfg(input logic [7:0] c, input logic [7:0] r, input logic [7:0] a,
                       input logic [7:0] b, input logic [13:0] off, input logic [7:0] en);
        wr(sps_pkg::ADDR_CTRL, c);
        wr(sps_pkg::ADDR_REFDIV, r);
        wr(sps_pkg::ADDR_OFF_LO, off[7:0]);
        wr(sps_pkg::ADDR_OFF_HI, {2'h0, off[13:8]});
        wr(sps_pkg::ADDR_A_ON, a);
        wr(sps_pkg::ADDR_B_ON, b);
        wr(sps_pkg::ADDR_CHAN_EN, en);
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : cfg

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(16'(reg_rdata), 16'(exp));
    endtask : rd_chk

    // One whole master period, answering each channel start after 3 cycles
    task automatic period(input bit done_en);
        int wn;
        wn  = 0;
        cyc = 0;
        st  = 0;
        idl = 0;
        onc = 0;
        idx_q.delete();
        b_q.delete();
        cy_q.delete();
        do begin
            @(posedge sys_clk);
            search_done <= 1'b0;
            #1;
        end while (period_start !== 1'b1);
        do begin
            @(posedge sys_clk);
            search_done <= done_en && (wn == 1);
            if (wn > 0) wn--;
            #1;
            cyc++;
            if (rx_on === 1'b1) onc++;
            if (idle_period === 1'b1) idl++;
            if (chan_start === 1'b1) begin
                st++;
                wn = 3;
                idx_q.push_back(search_index);
                b_q.push_back(search_cfg_b);
                cy_q.push_back(cyc);
            end
        end while (period_start !== 1'b1);
    endtask : period

    function automatic logic [15:0] ticks(input int n, input int t);
        return 16'((n + t / 2) / t);
    endfunction : ticks

    task automatic t_regs;
        rd_chk(sps_pkg::ADDR_CTRL, 8'h00);
        rd_chk(8'h20, 8'h00);
        rd_chk(sps_pkg::ADDR_STATUS, 8'h10);
    endtask : t_regs

    task automatic t_const;
        logic [7:0] cv[2];
        cv[0] = 8'h00;
        cv[1] = 8'hf3;
        for (int i = 0; i < 2; i++) begin
            cfg(cv[i], 8'h04, 8'h03, 8'h04, 14'h0005, 8'h13);
            period(1'b1);
            chk(ticks(cyc, PS * 4), 16'h000f);
            chk(16'(st), 16'h0003);
        end
    endtask : t_const

    task automatic t_fast;
        cfg(8'h01, 8'h04, 8'h06, 8'h09, 14'h0005, 8'h13);
        period(1'b1);
        chk(ticks(cyc, PS * 4), 16'h000b);
        chk(16'(st), 16'h0003);
        chk(16'(idx_q[2]), 16'(sps_pkg::NUM_A));
        chk(16'(b_q[2]), 16'h0001);
        chk(16'(onc < 40), 16'h0001);
    endtask : t_fast

    task automatic t_mixed;
        cfg(8'h02, 8'h04, 8'h03, 8'h04, 14'h0005, 8'h33);
        period(1'b1);
        chk(ticks(cyc, PS * 4), 16'h000f);
        chk(16'(st), 16'h0004);
        chk(ticks(cy_q[1] - cy_q[0], PS * 4), 16'h0003);
        chk(16'(b_q[3]), 16'h0001);
    endtask : t_mixed

    task automatic t_perm;
        cfg(8'h08, 8'h04, 8'h08, 8'h04, 14'h0005, 8'h03);
        period(1'b1);
        chk(ticks(cyc, PS * 4), 16'h000d);
        chk(16'(st > 2), 16'h0001);
        chk(16'(idx_q[2]), 16'h0000);
        chk(16'(onc > 100), 16'h0001);
    endtask : t_perm

    task automatic t_ai;
        int n_idle;
        int s_idle;
        n_idle = 0;
        s_idle = 0;
        wr(sps_pkg::ADDR_ACTIVE, 8'h02);
        wr(sps_pkg::ADDR_IDLE, 8'h01);
        cfg(8'h05, 8'h04, 8'h02, 8'h04, 14'h0002, 8'h01);
        repeat (3) period(1'b1);
        repeat (6) begin
            period(1'b1);
            if (idl * 2 > cyc) begin
                n_idle++;
                s_idle += st;
            end
        end
        chk(16'(n_idle), 16'h0002);
        chk(16'(s_idle), 16'h0000);
    endtask : t_ai

    task automatic t_refdiv;
        cfg(8'h01, 8'h00, 8'h01, 8'h01, 14'h0001, 8'h01);
        period(1'b1);
        period(1'b1);
        chk(ticks(cyc, PS * 256), 16'h0002);
    endtask : t_refdiv

    initial begin
        resetn      = 1'b0;
        reg_addr    = 8'h00;
        reg_wdata   = 8'h00;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        search_done = 1'b0;
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        t_regs();
        t_const();
        t_fast();
        t_mixed();
        t_perm();
        t_ai();
        t_refdiv();
        complete_run();
    end

    initial begin
        repeat (60000) @(posedge sys_clk);
        bad_count++;
        complete_run();
    end
endmodule : sps_sequencer_tb_top
